// ===== logic/pin_io_cell.sv
// one switchable digital pin: pad synchroniser, input functions, output drive
// assumes its record and polarity come from registers on the same clock
`timescale 1ns/100ps
module pin_io_cell
    import teach_pin_cfg_pkg::*;
(
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_resetn,
    input  wire teach_pin_cfg_pkg::pin_cfg_s i_cfg,
    input  wire logic                        i_pnp,
    input  wire logic                        i_pin,
    input  wire logic                        i_area_hit,
    input  wire logic                        i_warning,
    input  wire logic                        i_trigger,
    output logic                             o_pin,
    output logic                             o_oe,
    output logic                             o_trig_pulse,
    output logic                             o_teach_pulse
);
    import teach_pin_cfg_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic pin;
        logic oe;
        logic trig;
        logic teach;
    } cell_s;

    cell_s cell_r;
    cell_s cell_nxt;
    logic  act_in;
    logic  src;
    logic  active;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        cell_nxt = cell_r;
        cell_nxt.sync1 = i_pin;
        cell_nxt.sync2 = cell_r.sync1;
        // sinking inputs read active low
        act_in = i_pnp ? cell_r.sync2 : ~cell_r.sync2;
        cell_nxt.prev = act_in;
        cell_nxt.trig = (i_cfg.dir == DIR_INPUT) && (i_cfg.in_fn == IN_TRIGGER)
                        && act_in && !cell_r.prev;
        cell_nxt.teach = (i_cfg.dir == DIR_INPUT) && (i_cfg.in_fn == IN_TEACH)
                         && act_in && !cell_r.prev;
        unique case (i_cfg.out_fn)
            OUT_SWITCH: src = i_area_hit;
            OUT_WARN:   src = i_warning;
            OUT_TRIG:   src = i_trigger;
            default:    src = 1'b0;
        endcase
        active = src ^ i_cfg.sense[0];
        // open transistor style: drive only while active, level by polarity
        cell_nxt.oe = (i_cfg.dir == DIR_OUTPUT) && (i_cfg.out_fn != OUT_OFF) && active;
        cell_nxt.pin = i_pnp;
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cell_r <= '0;
        end else begin
            cell_r <= cell_nxt;
        end
    end

    assign o_pin         = cell_r.pin;
    assign o_oe          = cell_r.oe;
    assign o_trig_pulse  = cell_r.trig;
    assign o_teach_pulse = cell_r.teach;

endmodule

// ===== logic/teach_pin_cfg_bank.sv
// teach and pin configuration bank with an apb4 register slave
// assumes pins are asynchronous; evaluation inputs share i_sys_clk
//
// Operation
// - teach storage byte at bit 16: 0 non-volatile, 1 only while powered
// - teach sensitivity byte at bit 8: 0 high, 1 medium, 2 low reserve
// - higher function reserve gives lower detection sensitivity, and vice versa
// - records are 32 bits and accessed only whole; partial writes refused
// - one polarity byte for all pins: 0 sinking, 1 sourcing; resets to 1
// - direction byte at bit 24: 0 output, 1 input; resets to 0
// - sense byte at bit 16: 0 light active, 1 dark active; resets to 0
// - input function byte at bit 8: 0 off, 1 trigger, 2 teach request
// - output function byte at bit 0: off, area switching, warning, trigger
// - teach starts from panel, command, or a pin teach input
`timescale 1ns/100ps
module teach_pin_cfg_bank
    import teach_pin_cfg_pkg::*;
#(
    parameter int NUM_PINS = 2
) (
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_resetn,
    input  wire teach_pin_cfg_pkg::apb_req_s i_apb,
    output teach_pin_cfg_pkg::apb_rsp_s      o_apb,
    input  wire logic [NUM_PINS-1:0]         i_pin,
    input  wire logic [NUM_PINS-1:0]         i_area_hit,
    input  wire logic                        i_warning,
    input  wire logic                        i_trigger,
    output logic [NUM_PINS-1:0]              o_pin,
    output logic [NUM_PINS-1:0]              o_pin_oe,
    output logic                             o_pnp_mode,
    output logic                             o_teach_volatile,
    output teach_pin_cfg_pkg::sens_e         o_sensitivity,
    output logic                             o_trigger_pulse,
    output logic                             o_teach_req_pulse
);
    import teach_pin_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // elaboration check

    if (NUM_PINS < 1 || NUM_PINS > MAX_PINS) begin : g_bad_pins
        $error("NUM_PINS must lie between 1 and MAX_PINS");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic                      pready;
        logic [DATA_W-1:0]         prdata;
        logic                      pslverr;
        logic [7:0]                pol;
        teach_cfg_s                teach;
        pin_cfg_s [NUM_PINS-1:0]   pins;
        sens_e                     sens;
        logic                      trig;
        logic                      teach_req;
    } bank_s;

    bank_s                         bank_r;
    bank_s                         bank_nxt;
    logic [NUM_PINS-1:0]           trig_hit;
    logic [NUM_PINS-1:0]           teach_hit;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic reg_sel_e sel_of(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        reg_sel_e   sel;
        idx = addr[9:2];
        sel = SEL_NONE;
        if (addr[1:0] == 2'b00 && addr[ADDR_W-1:10] == '0) begin
            if (idx == IDX_POLARITY) begin
                sel = SEL_POL;
            end else if (idx == IDX_TEACH) begin
                sel = SEL_TEACH;
            end
            for (int k = 0; k < NUM_PINS; k++) begin
                if (idx == IDX_PIN[k]) begin
                    sel = SEL_PIN;
                end
            end
        end
        return sel;
    endfunction

    function automatic int pin_of(input logic [ADDR_W-1:0] addr);
        int n;
        n = 0;
        for (int k = 0; k < NUM_PINS; k++) begin
            if (addr[9:2] == IDX_PIN[k]) begin
                n = k;
            end
        end
        return n;
    endfunction

    function automatic logic pin_ok(input pin_cfg_s c);
        return (c.dir <= DIR_MAX) && (c.sense <= SENSE_MAX)
               && (c.in_fn <= IN_MAX) && (c.out_fn <= OUT_MAX);
    endfunction

    function automatic logic teach_ok(input teach_cfg_s c);
        return (c.storage <= STORE_MAX) && (c.sens <= SENS_MAX);
    endfunction

    // higher reserve means less sensitive detection
    function automatic sens_e sens_of(input logic [7:0] reserve);
        sens_e s;
        unique case (reserve)
            RES_LOW: s = SENS_HIGH;
            RES_MED: s = SENS_MED;
            default: s = SENS_LOW;
        endcase
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register file and apb slave

    logic        setup;
    logic        access;
    reg_sel_e    sel;
    int          pin_n;
    logic        wr_ok;
    pin_cfg_s    wr_pin;
    teach_cfg_s  wr_teach;

    always_comb begin
        bank_nxt  = bank_r;
        setup     = i_apb.psel && !i_apb.penable && !bank_r.pready;
        access    = i_apb.psel && i_apb.penable && bank_r.pready;
        sel       = sel_of(i_apb.paddr);
        pin_n     = pin_of(i_apb.paddr);
        wr_pin    = pin_cfg_s'(i_apb.pwdata);
        wr_teach  = teach_cfg_s'(i_apb.pwdata);
        wr_ok     = 1'b0;
        bank_nxt.pready = 1'b0;

        unique case (sel)
            SEL_POL:   wr_ok = i_apb.pwdata[31:8] == '0
                               && i_apb.pwdata[7:0] <= POL_MAX;
            SEL_TEACH: wr_ok = teach_ok(wr_teach);
            SEL_PIN:   wr_ok = pin_ok(wr_pin);
            SEL_NONE:  wr_ok = 1'b0;
        endcase
        // only whole-record writes are served
        wr_ok = wr_ok && (i_apb.pstrb == STRB_ALL);

        if (setup) begin
            bank_nxt.pready  = 1'b1;
            bank_nxt.prdata  = '0;
            bank_nxt.pslverr = (sel == SEL_NONE) || (i_apb.pwrite && !wr_ok);
            if (!i_apb.pwrite) begin
                unique case (sel)
                    SEL_POL:   bank_nxt.prdata = {24'h00_0000, bank_r.pol};
                    SEL_TEACH: bank_nxt.prdata = {8'h00, bank_r.teach.storage,
                                                  bank_r.teach.sens, 8'h00};
                    SEL_PIN:   bank_nxt.prdata = bank_r.pins[pin_n];
                    SEL_NONE:  bank_nxt.prdata = '0;
                endcase
            end
        end

        // write lands only at the edge the master samples pready
        if (access && i_apb.pwrite && !bank_r.pslverr) begin
            unique case (sel)
                SEL_POL:   bank_nxt.pol = i_apb.pwdata[7:0];
                SEL_TEACH: begin
                    bank_nxt.teach.storage = wr_teach.storage;
                    bank_nxt.teach.sens    = wr_teach.sens;
                end
                SEL_PIN:   bank_nxt.pins[pin_n] = wr_pin;
                SEL_NONE:  bank_nxt.pol = bank_r.pol;
            endcase
        end

        bank_nxt.sens      = sens_of(bank_r.teach.sens);
        bank_nxt.trig      = |trig_hit;
        bank_nxt.teach_req = |teach_hit;
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bank_r       <= '0;
            bank_r.pol   <= POL_RST;
            bank_r.teach <= TEACH_RST;
            bank_r.pins  <= {NUM_PINS{PIN_RST}};
            bank_r.sens  <= SENS_LOW;
        end else begin
            bank_r <= bank_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-pin logic

    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
        pin_io_cell u_cell (
            .i_sys_clk     (i_sys_clk),
            .i_resetn      (i_resetn),
            .i_cfg         (bank_r.pins[g]),
            .i_pnp         (bank_r.pol[0]),
            .i_pin         (i_pin[g]),
            .i_area_hit    (i_area_hit[g]),
            .i_warning     (i_warning),
            .i_trigger     (i_trigger),
            .o_pin         (o_pin[g]),
            .o_oe          (o_pin_oe[g]),
            .o_trig_pulse  (trig_hit[g]),
            .o_teach_pulse (teach_hit[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_apb.pready      = bank_r.pready;
    assign o_apb.prdata      = bank_r.prdata;
    assign o_apb.pslverr     = bank_r.pslverr;
    assign o_pnp_mode        = bank_r.pol[0];
    assign o_teach_volatile  = bank_r.teach.storage[0];
    assign o_sensitivity     = bank_r.sens;
    assign o_trigger_pulse   = bank_r.trig;
    assign o_teach_req_pulse = bank_r.teach_req;

endmodule

// ===== logic/teach_pin_cfg_pkg.sv
// teach and pin configuration bank: shared constants, record layouts, carriers
// assumes a 32-bit apb4 master; register index times four is the byte address
package teach_pin_cfg_pkg;

    localparam int          ADDR_W     = 12;
    localparam int          DATA_W     = 32;
    localparam int          MAX_PINS   = 2;

    // register indices; byte address is index * 4
    localparam logic [7:0]  IDX_POLARITY = 8'h4d;
    localparam logic [7:0]  IDX_TEACH    = 8'h4f;
    localparam logic [7:0]  IDX_PIN [MAX_PINS] = '{8'h50, 8'h53};

    // field positions inside a pin record and the teach record
    localparam int          PIN_DIR_LSB     = 24;
    localparam int          PIN_SENSE_LSB   = 16;
    localparam int          PIN_IN_LSB      = 8;
    localparam int          PIN_OUT_LSB     = 0;
    localparam int          TEACH_STORE_LSB = 16;
    localparam int          TEACH_SENS_LSB  = 8;

    // highest legal value of each field
    localparam logic [7:0]  POL_MAX   = 8'h01;
    localparam logic [7:0]  STORE_MAX = 8'h01;
    localparam logic [7:0]  SENS_MAX  = 8'h02;
    localparam logic [7:0]  DIR_MAX   = 8'h01;
    localparam logic [7:0]  SENSE_MAX = 8'h01;
    localparam logic [7:0]  IN_MAX    = 8'h02;
    localparam logic [7:0]  OUT_MAX   = 8'h03;

    // reset values and the full write strobe
    localparam logic [7:0]  POL_RST   = 8'h01;
    localparam logic [31:0] TEACH_RST = 32'h0000_0000;
    localparam logic [31:0] PIN_RST   = 32'h0000_0000;
    localparam logic [3:0]  STRB_ALL  = 4'hf;

    typedef enum logic [7:0] {
        DIR_OUTPUT = 8'h00,
        DIR_INPUT  = 8'h01
    } pin_dir_e;

    typedef enum logic [7:0] {
        IN_OFF     = 8'h00,
        IN_TRIGGER = 8'h01,
        IN_TEACH   = 8'h02
    } in_fn_e;

    typedef enum logic [7:0] {
        OUT_OFF    = 8'h00,
        OUT_SWITCH = 8'h01,
        OUT_WARN   = 8'h02,
        OUT_TRIG   = 8'h03
    } out_fn_e;

    typedef enum logic [7:0] {
        RES_HIGH = 8'h00,
        RES_MED  = 8'h01,
        RES_LOW  = 8'h02
    } reserve_e;

    // detection sensitivity handed to the evaluation logic
    typedef enum logic [1:0] {
        SENS_LOW  = 2'b00,
        SENS_MED  = 2'b01,
        SENS_HIGH = 2'b10
    } sens_e;

    typedef enum logic [1:0] {
        SEL_NONE  = 2'b00,
        SEL_POL   = 2'b01,
        SEL_TEACH = 2'b10,
        SEL_PIN   = 2'b11
    } reg_sel_e;

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] sense;
        logic [7:0] in_fn;
        logic [7:0] out_fn;
    } pin_cfg_s;

    typedef struct packed {
        logic [7:0] rsvd_hi;
        logic [7:0] storage;
        logic [7:0] sens;
        logic [7:0] rsvd_lo;
    } teach_cfg_s;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [3:0]        pstrb;
    } apb_req_s;

    typedef struct packed {
        logic              pready;
        logic [DATA_W-1:0] prdata;
        logic              pslverr;
    } apb_rsp_s;

endpackage

// ===== tb/teach_pin_cfg_bank_sva.sv
// assertions on the apb slave and the mode and pulse outputs of the configuration bank
// assumes it is bound onto teach_pin_cfg_bank and sees only its ports
`timescale 1ns/100ps
module teach_pin_cfg_bank_chk
    import teach_pin_cfg_pkg::*;
#(
    parameter int NUM_PINS = 2
) (
    input wire logic                        i_sys_clk,
    input wire logic                        i_resetn,
    input wire teach_pin_cfg_pkg::apb_req_s i_apb,
    input wire teach_pin_cfg_pkg::apb_rsp_s o_apb,
    input wire logic [NUM_PINS-1:0]         i_pin,
    input wire logic [NUM_PINS-1:0]         i_area_hit,
    input wire logic                        i_warning,
    input wire logic                        i_trigger,
    input wire logic [NUM_PINS-1:0]         o_pin,
    input wire logic [NUM_PINS-1:0]         o_pin_oe,
    input wire logic                        o_pnp_mode,
    input wire logic                        o_teach_volatile,
    input wire teach_pin_cfg_pkg::sens_e    o_sensitivity,
    input wire logic                        o_trigger_pulse,
    input wire logic                        o_teach_req_pulse
);
    import teach_pin_cfg_pkg::*;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    wire logic acc = i_apb.psel & i_apb.penable & o_apb.pready;
    wire logic wok = acc & i_apb.pwrite & ~o_apb.pslverr;
    ////////////////////////////////////////////////////////////////////////////
    a_zero_wait: assert property (i_apb.psel && !i_apb.penable |=> o_apb.pready)
        else $error("pready missing in access cycle");
    a_ready_single: assert property (o_apb.pready |=> !o_apb.pready)
        else $error("pready held too long");
    a_part_refused: assert property (acc && i_apb.pwrite && i_apb.pstrb != 4'hf |-> o_apb.pslverr)
        else $error("partial write accepted");
    a_unmapped_err: assert property (acc && !(i_apb.paddr inside {12'h134, 12'h13c, 12'h140, 12'h14c})
        |-> o_apb.pslverr)
        else $error("unmapped access accepted");
    a_pol_range: assert property (acc && i_apb.pwrite && i_apb.paddr == 12'h134 && i_apb.pwdata > 1
        |-> o_apb.pslverr)
        else $error("polarity out of range accepted");
    a_pol_update: assert property (wok && i_apb.paddr == 12'h134 |=> o_pnp_mode == $past(i_apb.pwdata[0]))
        else $error("polarity output not updated");
    a_store_update: assert property (wok && i_apb.paddr == 12'h13c
        |=> o_teach_volatile == $past(i_apb.pwdata[16]))
        else $error("storage output not updated");
    a_sens_map: assert property (wok && i_apb.paddr == 12'h13c
        |=> ##1 o_sensitivity == $past(i_apb.pwdata[9:8], 2))
        else $error("sensitivity mapping wrong");
    a_pnp_reset: assert property ($rose(i_resetn) |-> o_pnp_mode)
        else $error("polarity not sourcing after reset");
    a_trig_once: assert property (o_trigger_pulse |=> !o_trigger_pulse)
        else $error("trigger pulse too long");
    a_teach_once: assert property (o_teach_req_pulse |=> !o_teach_req_pulse)
        else $error("teach pulse too long");
endmodule

// ===== tb/teach_pin_cfg_bank_tb.sv
// bench for the configuration bank: apb tasks, integer register model, pin checks
// assumes the package, the design and the checker are compiled before it
`timescale 1ns/100ps
module teach_pin_cfg_bank_tb;
    import teach_pin_cfg_pkg::*;
    logic        clk = 0;
    logic        rstn = 0;
    apb_req_s    req = '0;
    apb_rsp_s    rsp;
    logic [1:0]  pin = 0, hit = 0, pout, poe;
    logic        warn = 0, trg = 0, pnp, tvol, tp, tr, err;
    sens_e       sens;
    logic [31:0] rd;
    int          n_mismatch = 0, checks_done = 0, seed = 57608;
    int          pol, teach, cfg [2];
    int          addrs [6] = '{12'h134, 12'h13c, 12'h140, 12'h14c, 12'h138, 12'h135};

    teach_pin_cfg_bank #(.NUM_PINS(2)) DUT (.i_sys_clk(clk), .i_resetn(rstn), .i_apb(req), .o_apb(rsp),
        .i_pin(pin), .i_area_hit(hit), .i_warning(warn), .i_trigger(trg), .o_pin(pout), .o_pin_oe(poe),
        .o_pnp_mode(pnp), .o_teach_volatile(tvol), .o_sensitivity(sens), .o_trigger_pulse(tp),
        .o_teach_req_pulse(tr));

    initial forever #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic bad(int a, logic [31:0] d, logic [3:0] s, logic w);
        if (!(a inside {12'h134, 12'h13c, 12'h140, 12'h14c})) return 1;
        if (!w) return 0;
        if (s != 4'hf) return 1;
        if (a == 12'h134) return d > 1;
        if (a == 12'h13c) return d[23:16] > 1 || d[15:8] > 2;
        return d[31:24] > 1 || d[23:16] > 1 || d[15:8] > 2 || d[7:0] > 3;
    endfunction

    function automatic logic oe_exp(int j);
        logic src;
        src = cfg[j][7:0] == 1 ? hit[j] : cfg[j][7:0] == 2 ? warn : trg;
        return cfg[j][31:24] == 0 && cfg[j][7:0] != 0 && (src ^ cfg[j][16]);
    endfunction

    // one idle edge first so a release and the next setup never share a time step
    task automatic apb(int a, logic w, logic [31:0] d, logic [3:0] s);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a[11:0], d, s};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask

    task automatic wr(int a, logic [31:0] d, logic [3:0] s);
        logic e;
        e = bad(a, d, s, 1);
        apb(a, 1, d, s);
        chk("write error", err, e);
        if (!e && a == 12'h134) pol = d;
        if (!e && a == 12'h13c) teach = d & 32'h00ff_ff00;
        if (!e && a == 12'h140) cfg[0] = d;
        if (!e && a == 12'h14c) cfg[1] = d;
    endtask

    task automatic rdchk(int a);
        apb(a, 0, 0, 4'hf);
        chk("read error", err, bad(a, 0, 0, 0));
        if (a == 12'h134) chk("polarity", rd, pol);
        if (a == 12'h13c) chk("teach record", rd, teach);
        if (a == 12'h140) chk("pin record 0", rd, cfg[0]);
        if (a == 12'h14c) chk("pin record 1", rd, cfg[1]);
        chk("pnp mode", pnp, pol[0]);
        chk("teach volatile", tvol, teach[16]);
        chk("sensitivity", sens, teach[9:8] == 0 ? SENS_LOW : teach[9:8] == 1 ? SENS_MED : SENS_HIGH);
    endtask

    task automatic do_reset();
        rstn <= 0;
        repeat (4) @(posedge clk);
        rstn <= 1;
        pol = 1;
        teach = 0;
        cfg = '{0, 0};
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int a, p, fn, pv, hits, at;
        do_reset();
        foreach (addrs[i]) rdchk(addrs[i]);
        for (int k = 0; k < 6; k++) begin
            wr(12'h13c, {8'hff, 8'(k % 2), 8'(k / 2), 8'hff}, 4'hf);
            rdchk(12'h13c);
        end
        // configuring side keeps teach values non-volatile, the usual choice
        wr(12'h13c, 32'h0000_0100, 4'hf);
        rdchk(12'h13c);
        repeat (60) begin
            a = addrs[$unsigned($random(seed)) % 6];
            wr(a, $random(seed) & 32'h0103_0307, ($random(seed) & 7) ? 4'hf : 4'h3);
            rdchk(a);
        end
        for (int k = 0; k < 64; k++) begin
            wr(12'h134, k[5], 4'hf);
            {warn, trg, hit} <= 4'($random(seed));
            wr(k[4] ? 12'h14c : 12'h140, {7'd0, k[3], 7'd0, k[2], 14'd0, k[1:0]}, 4'hf);
            @(posedge clk);
            #1;
            for (int j = 0; j < 2; j++) begin
                chk("pin enable", poe[j], oe_exp(j));
                if (oe_exp(j)) chk("pin level", pout[j], pol[0]);
            end
        end
        // pad edge to pulse is a fixed four edges through the synchroniser
        for (int k = 0; k < 8; k++) begin
            p = k % 2;
            fn = k[1] ? 2 : 1;
            pv = k / 4;
            wr(12'h134, pv, 4'hf);
            pin <= {2{~pv[0]}};
            wr(p ? 12'h14c : 12'h140, {8'd1, 8'd0, 8'(fn), 8'd0}, 4'hf);
            repeat (6) @(posedge clk);
            pin[p] <= pv[0];
            hits = 0;
            at = 0;
            for (int c = 1; c <= 8; c++) begin
                @(posedge clk);
                #1;
                if ((fn == 1 ? tp : tr) === 1'b1) hits++;
                if ((fn == 1 ? tp : tr) === 1'b1) at = c;
                if ((fn == 1 ? tr : tp) !== 1'b0) hits += 10;
            end
            chk("pulse count", hits, 1);
            chk("pulse delay", at, 4);
        end
        do_reset();
        foreach (addrs[i]) rdchk(addrs[i]);
        give_verdict();
    end

    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
endmodule

bind teach_pin_cfg_bank teach_pin_cfg_bank_chk #(.NUM_PINS(NUM_PINS)) u_chk (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_apb(i_apb), .o_apb(o_apb), .i_pin(i_pin),
    .i_area_hit(i_area_hit), .i_warning(i_warning), .i_trigger(i_trigger), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
    .o_pnp_mode(o_pnp_mode), .o_teach_volatile(o_teach_volatile), .o_sensitivity(o_sensitivity),
    .o_trigger_pulse(o_trigger_pulse), .o_teach_req_pulse(o_teach_req_pulse));
